/* core/pmd_mgmt_pkg.sv */
// Constants, carrier types and states shared by the medium management register block
package pmd_mgmt_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0] PMD_DEVAD = 5'h01;
    localparam logic [15:0] STATUS_TWO_ADDR = 16'h0008;
    localparam logic [15:0] TX_DISABLE_ADDR = 16'h0009;
    localparam logic [15:0] SIGNAL_DETECT_ADDR = 16'h000a;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PRESENCE_HI = 15;
    localparam int PRESENCE_LO = 14;
    localparam int TX_FAULT_ABILITY_BIT = 13;
    localparam int RX_FAULT_ABILITY_BIT = 12;
    localparam int TX_FAULT_FLAG_BIT = 11;
    localparam int RX_FAULT_LATCHED_BIT = 10;
    localparam int EXT_ABILITY_BIT = 9;
    localparam int TX_DISABLE_ABILITY_BIT = 8;
    localparam int OPTIC_ABILITY_HI = 7;
    localparam int OPTIC_ABILITY_LO = 1;
    localparam int LOOPBACK_ABILITY_BIT = 0;
    localparam int GLOBAL_BIT = 0;
    localparam int LANE_LO = 1;
    localparam int LANE_HI = 4;

    // ------------------------------------------------------------
    // Reset and fixed values
    // ------------------------------------------------------------
    localparam logic [1:0] PRESENCE_RST = 2'h2;
    localparam logic TX_FAULT_ABILITY_RST = 1'h0;
    localparam logic RX_FAULT_ABILITY_RST = 1'h1;
    localparam logic TX_FAULT_FLAG_RST = 1'h0;
    localparam logic RX_FAULT_LATCHED_RST = 1'h1;
    localparam logic EXT_ABILITY_RST = 1'h1;
    localparam logic TX_DISABLE_ABILITY_RST = 1'h1;
    localparam logic [6:0] OPTIC_ABILITY_RST = 7'h00;
    localparam logic LOOPBACK_ABILITY_RST = 1'h1;
    localparam logic [15:0] TX_DISABLE_RST = 16'h0000;
    localparam logic [4:0] SIGNAL_DETECT_RST = 5'h00;

    // ------------------------------------------------------------
    // Management frame
    // ------------------------------------------------------------
    localparam logic [1:0] OP_ADDRESS = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ_INC = 2'h2;
    localparam logic [1:0] OP_READ = 2'h3;
    localparam logic [5:0] HDR_BITS = 6'h0d;
    localparam logic [5:0] TURN_BITS = 6'h02;
    localparam logic [5:0] DATA_BITS = 6'h10;

    typedef struct packed {
        logic st_low;
        logic [1:0] op;
        logic [4:0] prt;
        logic [4:0] dev;
    } frame_hdr_type;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_type;

    typedef enum logic [1:0] {ST_PREAMBLE, ST_HEADER, ST_TURN, ST_DATA} frame_state_type;

endpackage

/* core/pin_sync3.sv */
// Three-stage input synchroniser that passes a level once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int WIDTH = 2
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pin_sync3 needs a width of at least one");
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // pin_sync3

/* core/pmd_mgmt_regs.sv */
// Medium status, transmit disable and signal detect registers behind a management slave
//
// What this block does
// - Status two sits at 0x0008, transmit disable at 0x0009, signal detect at 0x000A, device 1.
// - Status two bits 15:14 read binary 10 to show a device answers, reset value 2.
// - Status two bit 13 reads 0 because transmit faults cannot be detected.
// - Status two bit 12 reads 1 because receive faults can be detected.
// - Status two bit 11, the transmit fault flag, reads 0 as a reserved bit.
// - Status two bit 10 latches high on a receive fault and comes out of reset at 1.
// - Status two bit 9 reads 1 to announce the extended ability register.
// - Status two bit 8 reads 1 to announce that transmit can be disabled.
// - Status two bits 7 to 1 read 0 as no optical variant is supported.
// - Status two bit 0 reads 1 to announce loopback support.
// - Transmit disable bit 0 is a writable global off control resetting to 0.
// - Transmit disable bits 1 to 4 are writable per-lane off controls resetting to 0.
// - Signal detect bit 0 is read-only and shows 1 while a receive signal is seen, reset 0.
// - Signal detect bits 1 to 4 are read-only and show per-lane receive signal, reset 0.
`timescale 1ns/1ps
module pmd_mgmt_regs #(
    parameter int PORT_ADDR = 0,
    parameter int PREAMBLE_BITS = 32
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic rx_fault,
    input wire logic [4:0] rx_signal_seen,
    output logic global_tx_off,
    output logic [3:0] lane_tx_off
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0] pin_level;
    logic mdc_s, mdio_s, mdc_prev_q, mdc_rise;
    pmd_mgmt_pkg::frame_state_type state_q;
    logic [5:0] cnt_q;
    logic [12:0] hdr_q;
    logic [12:0] hdr_next;
    pmd_mgmt_pkg::frame_hdr_type hdr_n;
    logic hdr_match, mine_q;
    logic [1:0] op_q;
    logic [15:0] data_q, data_next, addr_q, rdata_q;
    logic rd_active_q;
    pmd_mgmt_pkg::pin_drive_type drive_q;
    logic [15:0] tx_dis_q;
    logic rx_fault_latched_q;
    logic [4:0] sig_seen_q;
    logic [3:0] lane_off_q;
    logic hdr_done, rd_capture, frame_end, wr_done;

    generate
        if (PREAMBLE_BITS < 1 || PREAMBLE_BITS > 63) begin : g_bad_preamble
            $error("preamble length must lie between 1 and 63");
        end
        if (PORT_ADDR < 0 || PORT_ADDR > 31) begin : g_bad_port
            $error("port address must lie between 0 and 31");
        end
    endgenerate

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    function automatic logic [15:0] read_word(input logic [15:0] addr, input logic latched,
                                              input logic [15:0] txd, input logic [4:0] seen);
        logic [15:0] w;
        w = 16'h0000;
        unique case (addr)
            pmd_mgmt_pkg::STATUS_TWO_ADDR: begin
                w[pmd_mgmt_pkg::PRESENCE_HI:pmd_mgmt_pkg::PRESENCE_LO] =
                    pmd_mgmt_pkg::PRESENCE_RST;
                w[pmd_mgmt_pkg::TX_FAULT_ABILITY_BIT] = pmd_mgmt_pkg::TX_FAULT_ABILITY_RST;
                w[pmd_mgmt_pkg::RX_FAULT_ABILITY_BIT] = pmd_mgmt_pkg::RX_FAULT_ABILITY_RST;
                w[pmd_mgmt_pkg::TX_FAULT_FLAG_BIT] = pmd_mgmt_pkg::TX_FAULT_FLAG_RST;
                w[pmd_mgmt_pkg::RX_FAULT_LATCHED_BIT] = latched;
                w[pmd_mgmt_pkg::EXT_ABILITY_BIT] = pmd_mgmt_pkg::EXT_ABILITY_RST;
                w[pmd_mgmt_pkg::TX_DISABLE_ABILITY_BIT] =
                    pmd_mgmt_pkg::TX_DISABLE_ABILITY_RST;
                w[pmd_mgmt_pkg::OPTIC_ABILITY_HI:pmd_mgmt_pkg::OPTIC_ABILITY_LO] =
                    pmd_mgmt_pkg::OPTIC_ABILITY_RST;
                w[pmd_mgmt_pkg::LOOPBACK_ABILITY_BIT] =
                    pmd_mgmt_pkg::LOOPBACK_ABILITY_RST;
            end
            pmd_mgmt_pkg::TX_DISABLE_ADDR: begin
                w = txd;
            end
            pmd_mgmt_pkg::SIGNAL_DETECT_ADDR: begin
                w[pmd_mgmt_pkg::LANE_HI:pmd_mgmt_pkg::GLOBAL_BIT] = seen;
            end
            default: begin
                w = 16'h0000;
            end
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    pin_sync3 #(.WIDTH(2)) u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .raw({mdc, mdio_in}),
        .level(pin_level)
    );

    assign mdc_s = pin_level[1];
    assign mdio_s = pin_level[0];
    assign mdc_rise = mdc_s & ~mdc_prev_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mdc_prev_q <= 1'h0;
        end else begin
            mdc_prev_q <= mdc_s;
        end
    end

    // ------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------
    assign hdr_next = {hdr_q[11:0], mdio_s};
    assign hdr_n = pmd_mgmt_pkg::frame_hdr_type'(hdr_next);
    assign hdr_match = !hdr_n.st_low && (hdr_n.prt == 5'(PORT_ADDR))
                       && (hdr_n.dev == pmd_mgmt_pkg::PMD_DEVAD);
    assign data_next = {data_q[14:0], mdio_s};
    assign hdr_done = mdc_rise && (state_q == pmd_mgmt_pkg::ST_HEADER)
                      && (cnt_q == pmd_mgmt_pkg::HDR_BITS - 6'h01);
    assign rd_capture = hdr_done && hdr_match && hdr_n.op[1];
    assign frame_end = mdc_rise && (state_q == pmd_mgmt_pkg::ST_DATA)
                       && (cnt_q == pmd_mgmt_pkg::DATA_BITS - 6'h01);
    assign wr_done = frame_end && mine_q && (op_q == pmd_mgmt_pkg::OP_WRITE);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_q <= pmd_mgmt_pkg::ST_PREAMBLE;
            cnt_q <= 6'h00;
            hdr_q <= 13'h0000;
            mine_q <= 1'h0;
            op_q <= 2'h0;
            data_q <= 16'h0000;
        end else if (mdc_rise) begin
            unique case (state_q)
                pmd_mgmt_pkg::ST_PREAMBLE: begin
                    if (mdio_s) begin
                        if (cnt_q != 6'h3f) begin
                            cnt_q <= cnt_q + 6'h01;
                        end
                    end else if (cnt_q >= 6'(PREAMBLE_BITS)) begin
                        state_q <= pmd_mgmt_pkg::ST_HEADER;
                        cnt_q <= 6'h00;
                    end else begin
                        cnt_q <= 6'h00;
                    end
                end
                pmd_mgmt_pkg::ST_HEADER: begin
                    hdr_q <= hdr_next;
                    if (cnt_q == pmd_mgmt_pkg::HDR_BITS - 6'h01) begin
                        state_q <= pmd_mgmt_pkg::ST_TURN;
                        cnt_q <= 6'h00;
                        mine_q <= hdr_match;
                        op_q <= hdr_n.op;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                pmd_mgmt_pkg::ST_TURN: begin
                    if (cnt_q == pmd_mgmt_pkg::TURN_BITS - 6'h01) begin
                        state_q <= pmd_mgmt_pkg::ST_DATA;
                        cnt_q <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                pmd_mgmt_pkg::ST_DATA: begin
                    data_q <= data_next;
                    if (cnt_q == pmd_mgmt_pkg::DATA_BITS - 6'h01) begin
                        state_q <= pmd_mgmt_pkg::ST_PREAMBLE;
                        cnt_q <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register address
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            addr_q <= 16'h0000;
        end else if (frame_end && mine_q) begin
            if (op_q == pmd_mgmt_pkg::OP_ADDRESS) begin
                addr_q <= data_next;
            end else if (op_q == pmd_mgmt_pkg::OP_READ_INC) begin
                addr_q <= addr_q + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data and pin drive
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rdata_q <= 16'h0000;
            rd_active_q <= 1'h0;
            drive_q <= '0;
        end else if (rd_capture) begin
            rdata_q <= read_word(addr_q, rx_fault_latched_q, tx_dis_q, sig_seen_q);
            rd_active_q <= 1'h1;
        end else if (mdc_rise && rd_active_q) begin
            if (state_q == pmd_mgmt_pkg::ST_TURN && cnt_q == 6'h00) begin
                drive_q <= '{out: 1'h0, oe: 1'h1};
            end else if (state_q == pmd_mgmt_pkg::ST_DATA
                         && cnt_q == pmd_mgmt_pkg::DATA_BITS - 6'h01) begin
                drive_q <= '0;
                rd_active_q <= 1'h0;
            end else begin
                drive_q <= '{out: rdata_q[15], oe: 1'h1};
                rdata_q <= {rdata_q[14:0], 1'h0};
            end
        end
    end

    assign mdio_out = drive_q.out;
    assign mdio_oe = drive_q.oe;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rx_fault_latched_q <= pmd_mgmt_pkg::RX_FAULT_LATCHED_RST;
        end else if (rx_fault) begin
            rx_fault_latched_q <= 1'h1;
        end else if (rd_capture && addr_q == pmd_mgmt_pkg::STATUS_TWO_ADDR) begin
            rx_fault_latched_q <= 1'h0;
        end
    end

    // Upper bits are stored so read-modify-write by software returns them intact
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tx_dis_q <= pmd_mgmt_pkg::TX_DISABLE_RST;
        end else if (wr_done && addr_q == pmd_mgmt_pkg::TX_DISABLE_ADDR) begin
            tx_dis_q <= data_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sig_seen_q <= pmd_mgmt_pkg::SIGNAL_DETECT_RST;
        end else begin
            sig_seen_q <= rx_signal_seen;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            lane_off_q <= 4'h0;
        end else begin
            lane_off_q <= tx_dis_q[pmd_mgmt_pkg::LANE_HI:pmd_mgmt_pkg::LANE_LO]
                          | {4{tx_dis_q[pmd_mgmt_pkg::GLOBAL_BIT]}};
        end
    end

    assign global_tx_off = tx_dis_q[pmd_mgmt_pkg::GLOBAL_BIT];
    assign lane_tx_off = lane_off_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_status_read;
        rd_capture && addr_q == pmd_mgmt_pkg::STATUS_TWO_ADDR;
    endsequence

    sequence s_turn_zero;
        ##[1:400] (mdio_oe && !mdio_out);
    endsequence

    property p_presence;
        s_status_read |=> rdata_q[15:14] == 2'h2;
    endproperty
    a_presence: assert property (p_presence) else $error("presence field wrong");
    property p_fixed_caps;
        s_status_read |=> rdata_q[13:11] == 3'h2 && rdata_q[9:0] == 10'h301;
    endproperty
    a_fixed_caps: assert property (p_fixed_caps) else $error("ability bits wrong");
    property p_fault_sets;
        rx_fault |=> rx_fault_latched_q;
    endproperty
    a_fault_sets: assert property (p_fault_sets) else $error("fault not latched");
    property p_fault_clears;
        s_status_read and !rx_fault |=> !rx_fault_latched_q
            && rdata_q[10] == $past(rx_fault_latched_q);
    endproperty
    a_fault_clears: assert property (p_fault_clears) else $error("fault read wrong");
    property p_tx_write;
        wr_done && addr_q == pmd_mgmt_pkg::TX_DISABLE_ADDR |=> tx_dis_q == $past(data_next)
            ##1 lane_tx_off == ($past(tx_dis_q[4:1]) | {4{$past(tx_dis_q[0])}});
    endproperty
    a_tx_write: assert property (p_tx_write) else $error("transmit disable wrong");
    // A write may clear the global bit on the next edge, so only the lanes are looked at then
    property p_tx_global;
        tx_dis_q[0] |-> global_tx_off ##1 lane_tx_off == 4'hf;
    endproperty
    a_tx_global: assert property (p_tx_global) else $error("global off ignored");
    property p_sig_read;
        rd_capture && addr_q == pmd_mgmt_pkg::SIGNAL_DETECT_ADDR |=>
            rdata_q == {11'h000, $past(sig_seen_q)} && sig_seen_q == $past(rx_signal_seen);
    endproperty
    a_sig_read: assert property (p_sig_read) else $error("signal detect wrong");
    property p_map_tx;
        rd_capture && addr_q == pmd_mgmt_pkg::TX_DISABLE_ADDR |=> rdata_q == $past(tx_dis_q);
    endproperty
    a_map_tx: assert property (p_map_tx) else $error("register map wrong");
    property p_turn;
        rd_capture |-> !mdio_oe ##0 s_turn_zero;
    endproperty
    a_turn: assert property (p_turn) else $error("turnaround not driven");
    property p_reset_vals;
        $rose(rst_b) |-> tx_dis_q == 16'h0000 && rx_fault_latched_q && sig_seen_q == 5'h00;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");

endmodule // pmd_mgmt_regs

/* verification/mdio_station.sv */
// Management station model that clocks frames onto the management pins
`timescale 1ns/1ps
module mdio_station #(
    parameter int HALF = 10
) (
    input wire logic ref_clk,
    input wire logic mdio_line,
    output logic mdc,
    output logic drive,
    output logic drive_en
);
    initial begin
        mdc = 1'b0;
        drive = 1'b1;
        drive_en = 1'b0;
    end
    // ------------------------------------------------------------
    // One bit: data set while the clock is low, line sampled just before the rise
    // ------------------------------------------------------------
    task automatic bit_cycle(input logic en, input logic val, output logic smp);
        @(negedge ref_clk);
        mdc = 1'b0;
        drive_en = en;
        drive = val;
        repeat (HALF) @(negedge ref_clk);
        smp = mdio_line;
        mdc = 1'b1;
        repeat (HALF) @(negedge ref_clk);
    endtask
    // ------------------------------------------------------------
    // Whole frame; in read frames the station lets go of the line for turnaround and data
    // ------------------------------------------------------------
    task automatic frame(input int npre, input logic [1:0] op, input logic [4:0] prt,
                         input logic [4:0] dev, input logic [15:0] wdata,
                         output logic [15:0] rdata, output logic ta_seen);
        logic [31:0] word;
        logic s;
        word = {2'b00, op, prt, dev, 2'b10, wdata};
        for (int i = 0; i < npre; i++) bit_cycle(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            bit_cycle(!(op[1] && i < 18), word[i], s);
            if (i == 16) ta_seen = s;
            if (i < 16) rdata[i] = s;
        end
        // Clock stands still between frames
        @(negedge ref_clk);
        mdc = 1'b0;
        drive_en = 1'b0;
        repeat (HALF) @(negedge ref_clk);
    endtask
endmodule // mdio_station

/* verification/pmd_mgmt_regs_bench.sv */
// Self-checking bench for the medium status, transmit disable and signal detect registers
`timescale 1ns/1ps
module pmd_mgmt_regs_bench;
    localparam logic [4:0] PORT = 5'h05;
    localparam int PRE = 8;
    localparam int LIMIT = 95000;
    localparam logic [15:0] ST = pmd_mgmt_pkg::STATUS_TWO_ADDR;
    localparam logic [15:0] TX = pmd_mgmt_pkg::TX_DISABLE_ADDR;
    localparam logic [15:0] SD = pmd_mgmt_pkg::SIGNAL_DETECT_ADDR;
    logic ref_clk, rst_b, rx_fault, mdio_out, mdio_oe, mdc, st_out, st_oe, global_tx_off;
    logic [4:0] rx_signal_seen;
    logic [3:0] lane_tx_off;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    integer seed = 53;
    // Line has a pull-up when nobody drives it
    wire mdio_line = mdio_oe ? mdio_out : (st_oe ? st_out : 1'b1);

    pmd_mgmt_regs #(.PORT_ADDR(PORT), .PREAMBLE_BITS(PRE)) u_pmd_mgmt_regs (
        .ref_clk(ref_clk), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio_line),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .rx_fault(rx_fault),
        .rx_signal_seen(rx_signal_seen), .global_tx_off(global_tx_off),
        .lane_tx_off(lane_tx_off));
    mdio_station #(.HALF(10)) u_mdio_station (
        .ref_clk(ref_clk), .mdio_line(mdio_line), .mdc(mdc), .drive(st_out),
        .drive_en(st_oe));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] status_exp(input logic fault);
        return {2'b10, 1'b0, 1'b1, 1'b0, fault, 1'b1, 1'b1, 7'h00, 1'b1};
    endfunction
    task automatic cmd(input int npre, input logic [1:0] op, input logic [4:0] prt,
                       input logic [4:0] dev, input logic [15:0] wd, output logic [15:0] rd);
        logic t;
        u_mdio_station.frame(npre, op, prt, dev, wd, rd, t);
        if (op[1]) begin
            check("turnaround", {15'h0, t}, 16'h0000);
            check("released", {15'h0, mdio_oe}, 16'h0000);
        end
    endtask
    task automatic put(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] x;
        cmd(PRE, pmd_mgmt_pkg::OP_ADDRESS, PORT, pmd_mgmt_pkg::PMD_DEVAD, a, x);
        cmd(PRE, pmd_mgmt_pkg::OP_WRITE, PORT, pmd_mgmt_pkg::PMD_DEVAD, d, x);
    endtask
    task automatic get(input logic [15:0] a, output logic [15:0] d);
        cmd(PRE, pmd_mgmt_pkg::OP_ADDRESS, PORT, pmd_mgmt_pkg::PMD_DEVAD, a, d);
        cmd(PRE, pmd_mgmt_pkg::OP_READ, PORT, pmd_mgmt_pkg::PMD_DEVAD, 16'h0000, d);
    endtask
    task automatic do_reset();
        @(negedge ref_clk);
        rst_b = 1'b0;
        repeat (4) @(negedge ref_clk);
        rst_b = 1'b1;
        @(negedge ref_clk);
        check("tx off", {11'h0, lane_tx_off, global_tx_off}, 16'h0000);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] v;
        logic [15:0] w;
        rst_b = 1'b0;
        rx_fault = 1'b0;
        rx_signal_seen = 5'h00;
        do_reset();
        get(ST, v);
        check("status", v, status_exp(1'b1));
        get(ST, v);
        check("status", v, status_exp(1'b0));
        get(SD, v);
        check("signal detect", v, 16'h0000);
        get(TX, v);
        check("tx disable", {11'h0, v[4:0]}, 16'h0000);
        rx_fault = 1'b1;
        repeat (3) @(negedge ref_clk);
        rx_fault = 1'b0;
        get(ST, v);
        check("status", v, status_exp(1'b1));
        get(ST, v);
        check("status", v, status_exp(1'b0));
        rx_fault = 1'b1;
        get(ST, v);
        check("status", v, status_exp(1'b1));
        get(ST, v);
        check("status", v, status_exp(1'b1));
        rx_fault = 1'b0;
        get(ST, v);
        check("status", v, status_exp(1'b1));
        get(TX, v);
        for (int i = 0; i < 8; i++) begin
            w = 16'($random(seed));
            if (i == 0) w[4:0] = 5'h1e;
            if (i == 1) w[4:0] = 5'h01;
            w = {v[15:5], w[4:0]};
            put(TX, w);
            check("global off", {15'h0, global_tx_off}, {15'h0, w[0]});
            check("lane off", {12'h0, lane_tx_off}, {12'h0, w[4:1] | {4{w[0]}}});
            rx_signal_seen = 5'($random(seed));
            get(SD, v);
            check("signal detect", v, {11'h0, rx_signal_seen});
            get(TX, v);
            check("tx disable", {11'h0, v[4:0]}, {11'h0, w[4:0]});
        end
        put(ST, 16'h0000);
        put(SD, 16'hffff);
        get(ST, v);
        check("status", v, status_exp(1'b0));
        cmd(PRE, pmd_mgmt_pkg::OP_ADDRESS, PORT ^ 5'h01, pmd_mgmt_pkg::PMD_DEVAD, TX, v);
        cmd(PRE, pmd_mgmt_pkg::OP_WRITE, PORT ^ 5'h01, pmd_mgmt_pkg::PMD_DEVAD, ~w, v);
        cmd(PRE, pmd_mgmt_pkg::OP_ADDRESS, PORT, 5'h03, TX, v);
        cmd(PRE, pmd_mgmt_pkg::OP_WRITE, PORT, 5'h03, ~w, v);
        cmd(PRE, pmd_mgmt_pkg::OP_ADDRESS, PORT, pmd_mgmt_pkg::PMD_DEVAD, TX, v);
        cmd(PRE - 1, pmd_mgmt_pkg::OP_WRITE, PORT, pmd_mgmt_pkg::PMD_DEVAD, {11'h0, ~w[4:0]}, v);
        check("global off", {15'h0, global_tx_off}, {15'h0, w[0]});
        cmd(PRE, pmd_mgmt_pkg::OP_ADDRESS, PORT, pmd_mgmt_pkg::PMD_DEVAD, ST, v);
        cmd(PRE, pmd_mgmt_pkg::OP_READ_INC, PORT, pmd_mgmt_pkg::PMD_DEVAD, 16'h0, v);
        check("status", v, status_exp(1'b0));
        cmd(PRE, pmd_mgmt_pkg::OP_READ_INC, PORT, pmd_mgmt_pkg::PMD_DEVAD, 16'h0, v);
        check("tx disable", {11'h0, v[4:0]}, {11'h0, w[4:0]});
        cmd(PRE, pmd_mgmt_pkg::OP_READ_INC, PORT, pmd_mgmt_pkg::PMD_DEVAD, 16'h0, v);
        check("signal detect", v, {11'h0, rx_signal_seen});
        cmd(PRE, pmd_mgmt_pkg::OP_READ, PORT, pmd_mgmt_pkg::PMD_DEVAD, 16'h0, v);
        check("unmapped", v, 16'h0000);
        do_reset();
        get(TX, v);
        check("tx disable", {11'h0, v[4:0]}, 16'h0000);
        get(ST, v);
        check("status", v, status_exp(1'b1));
        close_out();
    end
endmodule // pmd_mgmt_regs_bench
